/* hw/hlst_core.sv */
`default_nettype none
//Behaviour
//- Sticky latch catches any ready-line drop
//- Arm clears latch; completion tests it
//- Completed input with latch set discarded
//- Host ready line sampled every half-second
//- Ready off while up: hard down, flush, fillers, dead
//- Down host answers destination dead
//- Recognised filler messages are dropped
//- Own ready back: latch, flush, raise, fill
//- Host messages older than thirty seconds dropped
//- Deadline missed: tardy, flush, flap, fill
//- Host traffic returns host to up
//- Going-down stores status, cleared when up
//- Filler sub-type sets padding, at most nine
module hlst_core
   import hlst_pkg::*;
#(
   parameter longint SAMPLE_CYC = HLST_SAMPLE_CYC,
   parameter longint QUEUE_AGE_CYC = HLST_QUEUE_AGE_CYC,
   parameter int TW = 32
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Ready lines: host pin in, own ready out
   input wire logic i_host_ready,
   input wire logic i_node_ok,
   output logic o_node_ready,
   // Host input reception events
   input wire logic i_rx_arm,
   input wire logic i_rx_done,
   input wire logic [7:0] i_rx_type,
   input wire logic [3:0] i_rx_subtype,
   input wire logic [11:0] i_rx_status,
   output logic o_rx_accept,
   output logic o_rx_discard,
   // Queue to host: head age and delivery
   input wire logic i_q_head_valid,
   input wire logic i_q_head_taken,
   output logic o_q_drop_head,
   output logic o_q_flush,
   // Messages the node enqueues toward the host
   output logic o_enq_valid,
   output logic [7:0] o_enq_type,
   input wire logic i_enq_ready,
   // Reach attempts from other parties
   input wire logic i_reach_req,
   output logic o_reach_dead,
   // Status
   output logic [2:0] o_host_state,
   output logic o_latch,
   output logic [3:0] o_pad_words,
   output logic o_status_valid,
   output logic [15:0] o_status
);
   // Synchronised host ready
   logic host_rdy_s;
   hlst_sync u_sync (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_async(i_host_ready),
      .o_sync(host_rdy_s)
   );

   // Half-second sampling tick
   logic sample_tick;
   hlst_timer #(.WIDTH(TW)) u_sample (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_restart(1'b0),
      .i_run(1'b1),
      .i_limit(TW'(SAMPLE_CYC)),
      .o_expire(sample_tick)
   );

   // Age of the message at the queue head; restarts on each new head
   logic age_expire;
   hlst_timer #(.WIDTH(TW)) u_age (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_restart(i_q_head_taken || o_q_drop_head),
      .i_run(i_q_head_valid),
      .i_limit(TW'(QUEUE_AGE_CYC)),
      .o_expire(age_expire)
   );

   hlst_state_t state_q;
   hlst_seq_t seq_q;
   logic node_ok_q;
   logic flap_q;
   logic [3:0] fill_left_q;
   logic [7:0] flap_cnt_q;
   logic host_sampled_q;

   // Message classification and event decode
   logic is_filler;
   logic is_going_down;
   logic host_traffic;
   logic ready_drop;
   logic ready_rise;
   logic own_restore;
   logic tardy_evt;
   logic down;
   assign is_filler = i_rx_type == HLST_TYPE_FILLER;
   assign is_going_down = i_rx_type == HLST_TYPE_GOING_DOWN;
   assign host_traffic = (i_rx_done && !o_latch) || i_q_head_taken;
   assign ready_drop = sample_tick && !host_rdy_s;
   assign ready_rise = sample_tick && host_rdy_s && !host_sampled_q;
   assign own_restore = i_node_ok && !node_ok_q;
   assign tardy_evt = age_expire && state_q == HLST_UP && !ready_drop;
   assign down = state_q != HLST_UP;

   // Sampled host ready, for rise detection at half-second rate
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         host_sampled_q <= 1'b0;
      end else if (sample_tick) begin
         host_sampled_q <= host_rdy_s;
      end
   end

   // Own health, delayed for restore edge
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         node_ok_q <= 1'b0;
      end else begin
         node_ok_q <= i_node_ok;
      end
   end

   // Dropout latch; a drop in the arm cycle still sets it
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_latch <= 1'b1;
      end else if (!host_rdy_s || !o_node_ready) begin
         o_latch <= 1'b1;
      end else if (i_rx_arm) begin
         o_latch <= 1'b0;
      end
   end

   // Completion verdict; fillers never accepted
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rx_accept <= 1'b0;
         o_rx_discard <= 1'b0;
      end else begin
         o_rx_discard <= i_rx_done && (o_latch || is_filler);
         o_rx_accept <= i_rx_done && !o_latch && !is_filler;
      end
   end

   // Padding words from a clean filler, capped
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pad_words <= 4'h0;
      end else if (i_rx_done && !o_latch && is_filler) begin
         o_pad_words <= (i_rx_subtype > HLST_PAD_MAX) ? HLST_PAD_MAX : i_rx_subtype;
      end
   end

   // Host state table
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= HLST_HARD;
      end else begin
         case (state_q)
            HLST_UP: begin
               if (ready_drop) begin
                  state_q <= HLST_HARD;
               end else if (tardy_evt) begin
                  state_q <= HLST_TARDY;
               end
            end
            HLST_HARD: begin
               if (!ready_drop && (ready_rise || host_traffic)) begin
                  state_q <= HLST_UP;
               end
            end
            HLST_TARDY: begin
               if (ready_drop) begin
                  state_q <= HLST_HARD;
               end else if (host_traffic) begin
                  state_q <= HLST_UP;
               end
            end
            default: state_q <= HLST_HARD;
         endcase
      end
   end

   // Stored going-down status; cleared on return to up
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_status_valid <= 1'b0;
         o_status <= 16'h0000;
      end else if (i_rx_done && !o_latch && is_going_down) begin
         o_status_valid <= 1'b1;
         o_status <= {i_rx_subtype, i_rx_status};
      end else if (down && !ready_drop && (ready_rise || host_traffic)) begin
         o_status_valid <= 1'b0;
      end
   end

   // Destination-dead answer while down
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_reach_dead <= 1'b0;
      end else begin
         o_reach_dead <= i_reach_req && down;
      end
   end

   // Expired head dropped
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_q_drop_head <= 1'b0;
      end else begin
         o_q_drop_head <= age_expire && !o_q_drop_head;
      end
   end

   // Resync sequencer: flush, ready back, fillers, dead notice.
   // A new trigger mid-sequence restarts it, so the host always sees a full set.
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         seq_q <= HLST_SQ_IDLE;
         fill_left_q <= 4'h0;
         flap_q <= 1'b0;
         flap_cnt_q <= 8'h00;
      end else if (!i_node_ok) begin
         seq_q <= HLST_SQ_IDLE;
         flap_q <= 1'b0;
      end else if (own_restore) begin
         seq_q <= HLST_SQ_FLUSH;
         fill_left_q <= HLST_BOUNCE_FILLER_CNT;
         flap_q <= 1'b0;
      end else if (tardy_evt) begin
         seq_q <= HLST_SQ_FLUSH;
         fill_left_q <= HLST_FILLER_CNT;
         flap_q <= 1'b1;
         flap_cnt_q <= 8'(HLST_FLAP_CYC);
      end else if (ready_drop && state_q == HLST_UP) begin
         seq_q <= HLST_SQ_FLUSH;
         fill_left_q <= HLST_FILLER_CNT;
         flap_q <= 1'b0;
      end else begin
         case (seq_q)
            HLST_SQ_IDLE: seq_q <= HLST_SQ_IDLE;
            HLST_SQ_FLUSH: seq_q <= HLST_SQ_RAISE;
            HLST_SQ_RAISE: begin
               // Hold low for the flap time before raising ready
               if (flap_cnt_q > 8'h01) begin
                  flap_cnt_q <= flap_cnt_q - 8'h01;
               end else begin
                  flap_q <= 1'b0;
                  flap_cnt_q <= 8'h00;
                  seq_q <= HLST_SQ_FILL;
               end
            end
            HLST_SQ_FILL: begin
               if (o_enq_valid && i_enq_ready) begin
                  fill_left_q <= fill_left_q - 4'h1;
                  if (fill_left_q == 4'h1) begin
                     seq_q <= HLST_SQ_DEAD;
                  end
               end
            end
            HLST_SQ_DEAD: begin
               if (o_enq_valid && i_enq_ready) begin
                  seq_q <= HLST_SQ_IDLE;
               end
            end
            default: seq_q <= HLST_SQ_IDLE;
         endcase
      end
   end

   // Own ready: off while unhealthy, flapping or flushing; latch thus sets.
   // Also held low on the restore edge, or ready would return before the flush.
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_node_ready <= 1'b0;
      end else begin
         o_node_ready <= i_node_ok && !own_restore && !flap_q
            && !(seq_q == HLST_SQ_FLUSH);
      end
   end

   // Flush pulse and enqueue request
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_q_flush <= 1'b0;
         o_enq_valid <= 1'b0;
         o_enq_type <= 8'h00;
      end else begin
         o_q_flush <= seq_q == HLST_SQ_FLUSH;
         if (o_enq_valid && i_enq_ready) begin
            o_enq_valid <= 1'b0;
         end else if (!o_enq_valid && seq_q == HLST_SQ_FILL && fill_left_q != 4'h0) begin
            o_enq_valid <= 1'b1;
            o_enq_type <= HLST_TYPE_FILLER;
         end else if (!o_enq_valid && seq_q == HLST_SQ_DEAD) begin
            o_enq_valid <= 1'b1;
            o_enq_type <= HLST_TYPE_HOST_DEAD;
         end
      end
   end

   // State out
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_host_state <= 3'b010;
      end else begin
         o_host_state <= state_q;
      end
   end

   // Down host always answered dead one cycle later
   reach_dead_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (i_reach_req && down) |=> o_reach_dead)
      else $error("reach not answered dead");
   // Discard on latched completion
   latch_discard_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (i_rx_done && o_latch) |=> (o_rx_discard && !o_rx_accept))
      else $error("latched input not discarded");
   // Ready low forces latch
   latch_set_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (!o_node_ready) |=> o_latch)
      else $error("latch missed own ready low");
   // Filler never accepted
   filler_drop_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (i_rx_done && is_filler) |=> !o_rx_accept)
      else $error("filler accepted");
   // Padding never above nine
   pad_cap_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      o_pad_words <= HLST_PAD_MAX)
      else $error("padding above cap");
   // Sampled drop from up gives hard down
   hard_down_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (ready_drop && state_q == HLST_UP) |=> state_q == HLST_HARD ##1 o_q_flush)
      else $error("hard down sequence wrong");
   // Tardy triggers flush and ready flap
   sequence flap_s;
      o_q_flush ##1 !o_node_ready;
   endsequence
   tardy_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (tardy_evt && i_node_ok) |=> (state_q == HLST_TARDY) ##1 flap_s)
      else $error("tardy sequence wrong");
   // Traffic in tardy returns up
   back_up_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (state_q == HLST_TARDY && host_traffic && !ready_drop) |=> state_q == HLST_UP)
      else $error("tardy host not returned up");
   // Status cleared on coming up
   status_clr_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (down && !ready_drop && ready_rise && !(i_rx_done && is_going_down))
      |=> !o_status_valid)
      else $error("status kept after up");
endmodule
`default_nettype wire

/* hw/hlst_pkg.sv */
`default_nettype none
package hlst_pkg;
   // Message types carried in the type field
   localparam logic [7:0] HLST_TYPE_FILLER = 8'h04;
   localparam logic [7:0] HLST_TYPE_HOST_DEAD = 8'h0A;
   localparam logic [7:0] HLST_TYPE_GOING_DOWN = 8'h02;
   // Largest padding count a filler may ask for
   localparam logic [3:0] HLST_PAD_MAX = 4'h9;
   // Filler count queued after a ready-line drop seen by sampling
   localparam logic [3:0] HLST_FILLER_CNT = 4'h3;
   // Filler count queued after own ready line returns (bounce cover)
   localparam logic [3:0] HLST_BOUNCE_FILLER_CNT = 4'h6;
   // Clock and times
   localparam longint HLST_CLK_HZ = 125000000;
   localparam longint HLST_SAMPLE_MS = 500;
   localparam longint HLST_SAMPLE_CYC = (HLST_SAMPLE_MS * HLST_CLK_HZ) / 1000;
   localparam longint HLST_QUEUE_AGE_S = 30;
   localparam longint HLST_QUEUE_AGE_CYC = HLST_QUEUE_AGE_S * HLST_CLK_HZ;
   // Length of the deliberate low pulse on our ready line
   localparam longint HLST_FLAP_NS = 1000;
   localparam longint HLST_FLAP_CYC = (HLST_FLAP_NS * HLST_CLK_HZ) / 1000000000;
   // Host states, one-hot
   typedef enum logic [2:0] {
      HLST_UP = 3'b001,
      HLST_HARD = 3'b010,
      HLST_TARDY = 3'b100
   } hlst_state_t;
   // Resync sequencer states, one-hot
   typedef enum logic [4:0] {
      HLST_SQ_IDLE = 5'b00001,
      HLST_SQ_FLUSH = 5'b00010,
      HLST_SQ_RAISE = 5'b00100,
      HLST_SQ_FILL = 5'b01000,
      HLST_SQ_DEAD = 5'b10000
   } hlst_seq_t;
endpackage
`default_nettype wire

/* hw/hlst_sync.sv */
`default_nettype none
module hlst_sync
   import hlst_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Asynchronous level in, synchronised level out
   input wire logic i_async,
   output logic o_sync
);
   // First stage feeds only the second
   logic meta_q;
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= 1'b0;
         o_sync <= 1'b0;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule
`default_nettype wire

/* hw/hlst_timer.sv */
`default_nettype none
module hlst_timer
   import hlst_pkg::*;
#(
   parameter int WIDTH = 32
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Restart, limit and expiry pulse
   input wire logic i_restart,
   input wire logic i_run,
   input wire logic [WIDTH-1:0] i_limit,
   output logic o_expire
);
   // Counts up while running; one-cycle pulse at the limit
   logic [WIDTH-1:0] cnt_q;
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q <= '0;
         o_expire <= 1'b0;
      end else if (i_restart || !i_run) begin
         cnt_q <= '0;
         o_expire <= 1'b0;
      end else if (cnt_q >= i_limit - WIDTH'(1)) begin
         cnt_q <= '0;
         o_expire <= 1'b1;
      end else begin
         cnt_q <= cnt_q + WIDTH'(1);
         o_expire <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* tb/hlst_host_model.sv */
`default_nettype none
module hlst_host_model
   import hlst_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Bench controls: power state, slow draining
   input wire logic i_up,
   input wire logic i_slow,
   // Node facing lines
   input wire logic i_node_ready,
   input wire logic i_enq_valid,
   input wire logic [7:0] i_enq_type,
   output logic o_host_ready,
   output logic o_enq_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic stall_q; // Stretches handshakes when slow
   logic drop_q; // Host copy of the dropout latch
   int kept_q; // Messages kept after filler removal
   // Ready pin follows power only, settled before any traffic
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_host_ready <= 1'b0;
      end else begin
         o_host_ready <= i_up;
      end
   end
   // Slow host is ready only on every other cycle
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stall_q <= 1'b0;
      end else begin
         stall_q <= i_slow && !stall_q;
      end
   end
   assign o_enq_ready = !stall_q;
   // Fillers vanish; corrupted input dropped via own latch
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         drop_q <= 1'b1;
         kept_q <= 0;
      end else if (!i_node_ready || !o_host_ready) begin
         drop_q <= 1'b1;
      end else if (i_enq_valid && o_enq_ready) begin
         drop_q <= 1'b0;
         if (!drop_q && i_enq_type != HLST_TYPE_FILLER) begin
            kept_q <= kept_q + 1;
         end
      end
   end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`default_nettype none
module tb_top
   import hlst_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   // Stimulus, all valued at time zero
   logic i_core_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic host_up = 1'b1;
   logic slow = 1'b0;
   logic node_ok = 1'b0;
   logic rx_arm = 1'b0;
   logic rx_done = 1'b0;
   logic [7:0] rx_type = 8'h00;
   logic [3:0] rx_sub = 4'h0;
   logic [11:0] rx_stat = 12'h000;
   logic q_valid = 1'b0;
   logic q_taken = 1'b0;
   logic reach = 1'b0;
   // Design outputs and partner lines
   logic host_ready, enq_ready, node_ready, rx_acc, rx_dis, q_drop, q_flush;
   logic enq_valid, reach_dead, latch, stat_valid;
   logic [7:0] enq_type;
   logic [2:0] host_state;
   logic [3:0] pad_words;
   logic [15:0] status;
   // Reference model state
   int error_cnt = 0;
   int n_checks = 0;
   int n_flush = 0;
   int n_drop = 0;
   int latch_m = 1;
   logic [7:0] got_q[$];
   logic [15:0] rnd = 16'h84F2; // 34034
   // 125 MHz clock
   always #4 i_core_clk = ~i_core_clk;
   // Short sample and age counts keep the run brief
   hlst_core #(.SAMPLE_CYC(20), .QUEUE_AGE_CYC(50), .TW(32)) uut (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_host_ready(host_ready),
      .i_node_ok(node_ok), .o_node_ready(node_ready), .i_rx_arm(rx_arm),
      .i_rx_done(rx_done), .i_rx_type(rx_type), .i_rx_subtype(rx_sub),
      .i_rx_status(rx_stat), .o_rx_accept(rx_acc), .o_rx_discard(rx_dis),
      .i_q_head_valid(q_valid), .i_q_head_taken(q_taken), .o_q_drop_head(q_drop),
      .o_q_flush(q_flush), .o_enq_valid(enq_valid), .o_enq_type(enq_type),
      .i_enq_ready(enq_ready), .i_reach_req(reach), .o_reach_dead(reach_dead),
      .o_host_state(host_state), .o_latch(latch), .o_pad_words(pad_words),
      .o_status_valid(stat_valid), .o_status(status));
   hlst_host_model host (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_up(host_up), .i_slow(slow),
      .i_node_ready(node_ready), .i_enq_valid(enq_valid), .i_enq_type(enq_type),
      .o_host_ready(host_ready), .o_enq_ready(enq_ready));
   // Record handshakes toward the host and one-cycle pulses, mid-cycle where settled
   always @(negedge i_core_clk) begin
      if (enq_valid === 1'b1 && enq_ready === 1'b1) got_q.push_back(enq_type);
      if (q_flush === 1'b1) n_flush++;
      if (q_drop === 1'b1) n_drop++;
   end
   // Value compare
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Queue compare: n fillers then one dead notice
   task automatic chk_enq(input int n);
      int k;
      k = 0;
      while (got_q.size() < n + 1 && k < 2000) begin
         @(negedge i_core_clk);
         k++;
      end
      chk(16'(got_q.size()), 16'(n + 1), "enqueue count");
      foreach (got_q[i]) begin
         chk(16'(got_q[i]), 16'((i < n) ? HLST_TYPE_FILLER : HLST_TYPE_HOST_DEAD), "enq type");
      end
      got_q.delete();
   endtask
   // State compare after a bounded wait
   task automatic wait_state(input logic [2:0] s, input int lim);
      int k;
      k = 0;
      while (host_state !== s && k < lim) begin
         @(negedge i_core_clk);
         k++;
      end
      chk(16'(host_state), 16'(s), "host state");
   endtask
   // One-cycle pulses
   task automatic arm();
      @(posedge i_core_clk);
      rx_arm <= 1'b1;
      @(posedge i_core_clk);
      rx_arm <= 1'b0;
      latch_m = 0;
      @(negedge i_core_clk);
      chk(16'(latch), 16'(latch_m), "latch after arm");
   endtask
   task automatic poke_reach(input logic dead);
      @(posedge i_core_clk);
      reach <= 1'b1;
      @(posedge i_core_clk);
      reach <= 1'b0;
      @(negedge i_core_clk);
      chk(16'(reach_dead), 16'(dead), "reach answer");
   endtask
   // Host input completion with accept or discard expected
   task automatic rx(input logic [7:0] t, input logic [3:0] s, input logic [11:0] st);
      logic acc;
      acc = (latch_m == 0) && (t != HLST_TYPE_FILLER);
      @(posedge i_core_clk);
      rx_done <= 1'b1;
      rx_type <= t;
      rx_sub <= s;
      rx_stat <= st;
      @(posedge i_core_clk);
      rx_done <= 1'b0;
      @(negedge i_core_clk);
      chk(16'({rx_acc, rx_dis}), 16'({acc, !acc}), "accept/discard");
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // Hang guard, far beyond the few hundred cycles expected
   initial begin
      #(30000 * 8);
      error_cnt++;
      conclude();
   end
   // Main sequence
   initial begin
      repeat (4) @(negedge i_core_clk);
      chk(16'({node_ready, latch, host_state}), 16'h000A, "reset values");
      @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      node_ok <= 1'b1;
      chk_enq(6);
      wait_state(3'b001, 60);
      $display("test bring-up done");
      // Own ready glitch sets latch; input discarded, resync queued
      arm();
      rx(8'h00, 4'h0, 12'h000);
      rnd = lfsr(rnd);
      rx(HLST_TYPE_FILLER, rnd[3:0] % 4'hA, 12'h000);
      chk(16'(pad_words), 16'(rnd[3:0] % 4'hA), "pad words");
      @(posedge i_core_clk);
      node_ok <= 1'b0;
      @(posedge i_core_clk);
      node_ok <= 1'b1;
      latch_m = 1;
      repeat (4) @(negedge i_core_clk);
      chk(16'(latch), 16'h0001, "latch after drop");
      rx(8'h00, 4'h0, 12'h000);
      chk_enq(6);
      $display("test dropout latch done");
      // Going-down stored while host stays up
      arm();
      rnd = lfsr(rnd);
      rx(HLST_TYPE_GOING_DOWN, rnd[15:12], rnd[11:0]);
      chk(16'({stat_valid, host_state}), 16'h0009, "still up");
      chk(status, rnd, "stored status");
      poke_reach(1'b0);
      $display("test going down done");
      // Hard down by sampled ready line, then host returns
      n_flush = 0;
      @(posedge i_core_clk);
      host_up <= 1'b0;
      repeat (2) @(negedge i_core_clk);
      chk(16'(host_state), 16'h0001, "no instant sample");
      wait_state(3'b010, 30);
      latch_m = 1;
      chk_enq(3);
      chk(16'(n_flush > 0), 16'h0001, "flush seen");
      chk(16'(stat_valid), 16'h0001, "status kept down");
      poke_reach(1'b1);
      @(posedge i_core_clk);
      host_up <= 1'b1;
      repeat (3) rx(HLST_TYPE_FILLER, 4'h0, 12'h000);
      wait_state(3'b001, 30);
      chk(16'(stat_valid), 16'h0000, "status cleared");
      $display("test hard down done");
      // Tardy host with a slow drain
      n_drop = 0;
      @(posedge i_core_clk);
      slow <= 1'b1;
      q_valid <= 1'b1;
      wait_state(3'b100, 80);
      @(posedge i_core_clk);
      q_valid <= 1'b0;
      chk(16'(n_drop > 0), 16'h0001, "head aged out");
      repeat (8) @(negedge i_core_clk);
      chk(16'({node_ready, latch}), 16'h0001, "ready flapped");
      poke_reach(1'b1);
      chk_enq(3);
      repeat (150) @(negedge i_core_clk);
      chk(16'(node_ready), 16'h0001, "ready back");
      @(posedge i_core_clk);
      q_taken <= 1'b1;
      @(posedge i_core_clk);
      q_taken <= 1'b0;
      wait_state(3'b001, 5);
      // One dead notice survives each resync with ready lines up: bring-up, glitch, tardy
      chk(16'(host.kept_q), 16'h0003, "dead notices kept");
      $display("test tardy done");
      conclude();
   end
endmodule
`default_nettype wire
